// ---- hw/mie_core.sv ----
// execution core for step, skip, computed jump and global interrupt enable
// Contract
// - decrement register, result to accumulator or register
// - decrement sets zero flag on zero result
// - interrupt-off instruction clears global enable, one cycle
// - interrupt-on instruction sets global enable, one cycle
// - jump target is page bits and accumulator
// - jump unconditional, two cycles, flags untouched
// - increment register, result to accumulator or register
// - increment wraps, sets zero flag, one cycle
// - skip-increment steps register to chosen destination
// - zero result discards prefetched word as no-op
// - skip-increment one cycle, two when skipping
`timescale 1ns/1ps
module mie_core
    import mie_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic      [31:0]        hrdata,
    output logic                    hresp,
    output logic      [PC_W-1:0]    progAddr,
    input  wire logic [INSTR_W-1:0] progData,
    output logic                    globalIrqEnable
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [INSTR_W-1:0] instrQ;
    logic [PC_W-1:0]    pcQ;
    logic [DATA_W-1:0]  accQ;
    logic [DATA_W-1:0]  tpageQ;
    logic               zeroQ;
    logic               gieQ;
    logic               runQ;

    mie_bus_t           busStateQ;
    logic [11:0]        bAddrQ;
    logic               bHighQ;
    logic               bWriteQ;
    logic               hreadyoutQ;
    logic [31:0]        hrdataQ;
    logic               hrespQ;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [7:0]           opc;
    logic [REG_SEL_W-1:0] regSel;
    logic                 dstReg;
    logic                 isDec;
    logic                 isInc;
    logic                 isSkz;
    logic                 isJmp;
    logic                 isOff;
    logic                 isOn;
    logic                 isStep;
    logic                 skipTaken;
    logic                 flush;
    logic                 coreWr;

    assign opc    = instrQ[FLD_OPC_LSB +: 8];
    assign regSel = instrQ[FLD_REG_LSB +: REG_SEL_W];
    assign dstReg = instrQ[FLD_DST_BIT];
    assign isDec  = runQ && (opc == OP_REG_DECREMENT);
    assign isInc  = runQ && (opc == OP_REG_INCREMENT);
    assign isSkz  = runQ && (opc == OP_INCREMENT_SKIP_ZERO);
    assign isJmp  = runQ && (opc == OP_COMPUTED_JUMP);
    assign isOff  = runQ && (opc == OP_IRQ_GLOBAL_OFF);
    assign isOn   = runQ && (opc == OP_IRQ_GLOBAL_ON);
    assign isStep = isDec || isInc || isSkz;

    // ------------------------------------------------------------
    // data registers and step adder
    // ------------------------------------------------------------
    logic [DATA_W-1:0]    rdVal;
    logic [DATA_W-1:0]    busDreg;
    logic [DATA_W-1:0]    stepResult;
    logic                 stepZero;
    logic                 busDmemWr;
    logic                 dWrEn;
    logic [REG_SEL_W-1:0] dWrAddr;
    logic [DATA_W-1:0]    dWrData;

    mie_step_alu u_alu (
        .operand (rdVal),
        .step    (isDec ? STEP_DOWN : STEP_UP),
        .result  (stepResult),
        .isZero  (stepZero)
    );

    assign skipTaken = isSkz && stepZero;
    assign flush     = skipTaken || isJmp;
    assign coreWr    = isStep && dstReg;

    always_comb begin
        dWrEn   = coreWr || busDmemWr;
        dWrAddr = coreWr ? regSel : bAddrQ[7:2];
        dWrData = coreWr ? stepResult : hwdata[DATA_W-1:0];
    end

    mie_data_regs u_regs (
        .clock   (clock),
        .reset   (reset),
        .rdAddrA (regSel),
        .rdDataA (rdVal),
        .rdAddrB (bAddrQ[7:2]),
        .rdDataB (busDreg),
        .wrEn    (dWrEn),
        .wrAddr  (dWrAddr),
        .wrData  (dWrData)
    );

    // ------------------------------------------------------------
    // bus write strobes
    // ------------------------------------------------------------
    logic busWr;
    logic isDmem;

    assign busWr     = (busStateQ == BUS_DATA) && bWriteQ && !bHighQ;
    assign isDmem    = (bAddrQ[11:8] == ADDR_DMEM_PAGE);
    assign busDmemWr = busWr && isDmem && !runQ;

    // ------------------------------------------------------------
    // fetch: program counter and prefetch word
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            pcQ <= RST_PC;
        end else if (runQ) begin
            if (isJmp) begin
                pcQ <= {tpageQ[TPAGE_LSB +: 2], accQ};
            end else begin
                pcQ <= pcQ + 10'h001;
            end
        end else if (busWr && bAddrQ == ADDR_PC) begin
            pcQ <= hwdata[PC_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            instrQ <= RST_INSTR;
        end else if (!runQ || flush) begin
            instrQ <= RST_INSTR;
        end else begin
            instrQ <= progData;
        end
    end

    // ------------------------------------------------------------
    // accumulator, page and flags
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            accQ <= RST_ACCUM;
        end else if (isStep && !dstReg) begin
            accQ <= stepResult;
        end else if (busWr && !runQ && bAddrQ == ADDR_ACCUM) begin
            accQ <= hwdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tpageQ <= RST_TPAGE;
        end else if (busWr && !runQ && bAddrQ == ADDR_TPAGE) begin
            tpageQ <= hwdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            zeroQ <= RST_ZERO;
        end else if (isDec || isInc) begin
            zeroQ <= stepZero;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            gieQ <= RST_GIE;
        end else if (isOff) begin
            gieQ <= 1'b0;
        end else if (isOn) begin
            gieQ <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            runQ <= RST_RUN;
        end else if (busWr && bAddrQ == ADDR_CTRL) begin
            runQ <= hwdata[CTRL_RUN_BIT];
        end
    end

    // ------------------------------------------------------------
    // bus slave: one wait state per transfer
    // ------------------------------------------------------------
    logic [31:0] rdWord;

    always_comb begin
        rdWord = 32'h0000_0000;
        if (!bHighQ) begin
            if (isDmem) begin
                rdWord[DATA_W-1:0] = busDreg;
            end else begin
                case (bAddrQ)
                    ADDR_CTRL: begin
                        rdWord[CTRL_RUN_BIT] = runQ;
                    end
                    ADDR_STATUS: begin
                        rdWord[STAT_ZERO_BIT] = zeroQ;
                        rdWord[STAT_GIE_BIT]  = gieQ;
                        rdWord[STAT_RUN_BIT]  = runQ;
                    end
                    ADDR_ACCUM: begin
                        rdWord[DATA_W-1:0] = accQ;
                    end
                    ADDR_TPAGE: begin
                        rdWord[DATA_W-1:0] = tpageQ;
                    end
                    ADDR_PC: begin
                        rdWord[PC_W-1:0] = pcQ;
                    end
                    ADDR_INSTR: begin
                        rdWord[INSTR_W-1:0] = instrQ;
                    end
                    default: begin
                        rdWord = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            busStateQ  <= BUS_ADDR;
            bAddrQ     <= 12'h000;
            bHighQ     <= 1'b0;
            bWriteQ    <= 1'b0;
            hreadyoutQ <= 1'b1;
            hrdataQ    <= 32'h0000_0000;
        end else begin
            case (busStateQ)
                BUS_ADDR: begin
                    if (hsel && htrans[1] && hready) begin
                        busStateQ  <= BUS_DATA;
                        bAddrQ     <= haddr[11:0];
                        bHighQ     <= (haddr[31:12] != 20'h0_0000);
                        bWriteQ    <= hwrite;
                        hreadyoutQ <= 1'b0;
                    end else begin
                        hreadyoutQ <= 1'b1;
                    end
                end
                BUS_DATA: begin
                    busStateQ  <= BUS_ADDR;
                    hreadyoutQ <= 1'b1;
                    hrdataQ    <= bWriteQ ? 32'h0000_0000 : rdWord;
                end
                default: begin
                    busStateQ  <= BUS_ADDR;
                    hreadyoutQ <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            hrespQ <= 1'b0;
        end else begin
            hrespQ <= 1'b0;
        end
    end

    assign hreadyout       = hreadyoutQ;
    assign hrdata          = hrdataQ;
    assign hresp           = hrespQ;
    assign progAddr        = pcQ;
    assign globalIrqEnable = gieQ;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    dec_to_acc_a: assert property (@(posedge clock) disable iff (reset)
        isDec && !dstReg |=> accQ == $past(rdVal) - 8'h01)
        else $error("decrement to accumulator wrong");

    dec_zero_a: assert property (@(posedge clock) disable iff (reset)
        isDec |=> zeroQ == ($past(rdVal) == 8'h01))
        else $error("decrement zero flag wrong");

    gie_off_a: assert property (@(posedge clock) disable iff (reset)
        isOff |=> !gieQ && !globalIrqEnable)
        else $error("global enable not cleared");

    gie_on_a: assert property (@(posedge clock) disable iff (reset)
        isOn |=> gieQ && globalIrqEnable)
        else $error("global enable not set");

    jump_target_a: assert property (@(posedge clock) disable iff (reset)
        isJmp |=> progAddr == {$past(tpageQ[1:0]), $past(accQ)})
        else $error("jump target wrong");

    jump_cost_a: assert property (@(posedge clock) disable iff (reset)
        isJmp ##1 runQ |-> opc == OP_NOP && $stable(zeroQ))
        else $error("jump did not flush or touched flags");

    inc_wrap_a: assert property (@(posedge clock) disable iff (reset)
        isInc && !dstReg && rdVal == 8'hFF |=> accQ == 8'h00 && zeroQ)
        else $error("increment wrap wrong");

    reg_write_a: assert property (@(posedge clock) disable iff (reset)
        isStep && dstReg |-> dWrEn && dWrAddr == instrQ[5:0])
        else $error("register writeback address wrong");

    skip_nop_a: assert property (@(posedge clock) disable iff (reset)
        isSkz && rdVal == 8'hFF ##1 runQ |-> opc == OP_NOP)
        else $error("skip did not discard prefetch");

    no_skip_a: assert property (@(posedge clock) disable iff (reset)
        isSkz && rdVal != 8'hFF ##1 runQ |-> instrQ == $past(progData))
        else $error("no-skip lost the prefetch");

    skz_acc_a: assert property (@(posedge clock) disable iff (reset)
        isSkz && !dstReg |=> accQ == $past(rdVal) + 8'h01 && $stable(zeroQ))
        else $error("skip-increment result wrong");

    prefetch_a: assert property (@(posedge clock) disable iff (reset)
        runQ && !flush |=> instrQ == $past(progData))
        else $error("prefetch word not carried");
endmodule

// ---- hw/mie_pkg.sv ----
// constants and types for the increment, decrement, jump and interrupt-enable core
package mie_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int INSTR_W   = 16;
    localparam int DATA_W    = 8;
    localparam int PC_W      = 10;
    localparam int REG_SEL_W = 6;
    localparam int REG_COUNT = 64;

    // ------------------------------------------------------------
    // instruction word layout and opcodes
    // ------------------------------------------------------------
    localparam int FLD_OPC_LSB = 8;
    localparam int FLD_DST_BIT = 6;
    localparam int FLD_REG_LSB = 0;
    localparam int TPAGE_LSB   = 0;

    localparam logic [7:0] OP_NOP                = 8'h00;
    localparam logic [7:0] OP_REG_DECREMENT      = 8'h01;
    localparam logic [7:0] OP_REG_INCREMENT      = 8'h02;
    localparam logic [7:0] OP_INCREMENT_SKIP_ZERO = 8'h03;
    localparam logic [7:0] OP_COMPUTED_JUMP      = 8'h04;
    localparam logic [7:0] OP_IRQ_GLOBAL_OFF     = 8'h05;
    localparam logic [7:0] OP_IRQ_GLOBAL_ON      = 8'h06;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_ACCUM     = 12'h008;
    localparam logic [11:0] ADDR_TPAGE     = 12'h00C;
    localparam logic [11:0] ADDR_PC        = 12'h010;
    localparam logic [11:0] ADDR_INSTR     = 12'h014;
    localparam logic [3:0]  ADDR_DMEM_PAGE = 4'h1;

    localparam int CTRL_RUN_BIT  = 0;
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_GIE_BIT  = 1;
    localparam int STAT_RUN_BIT  = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0]  RST_ACCUM = 8'h00;
    localparam logic [DATA_W-1:0]  RST_TPAGE = 8'h00;
    localparam logic [DATA_W-1:0]  RST_DREG  = 8'h00;
    localparam logic [PC_W-1:0]    RST_PC    = 10'h000;
    localparam logic [INSTR_W-1:0] RST_INSTR = 16'h0000;
    localparam logic               RST_GIE   = 1'b0;
    localparam logic               RST_ZERO  = 1'b0;
    localparam logic               RST_RUN   = 1'b0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        BUS_ADDR = 1'b0,
        BUS_DATA = 1'b1
    } mie_bus_t;

    typedef enum logic [0:0] {
        STEP_UP   = 1'b0,
        STEP_DOWN = 1'b1
    } mie_step_t;

endpackage

// ---- hw/mie_step_alu.sv ----
// one-step adder: plus or minus one, modulo 256, with zero detect
`timescale 1ns/1ps
module mie_step_alu
    import mie_pkg::*;
(
    input  wire logic [DATA_W-1:0] operand,
    input  wire mie_step_t         step,
    output logic      [DATA_W-1:0] result,
    output logic                   isZero
);
    // ------------------------------------------------------------
    // step and zero
    // ------------------------------------------------------------
    always_comb begin
        if (step == STEP_DOWN) begin
            result = operand - 8'h01;
        end else begin
            result = operand + 8'h01;
        end
        isZero = (result == 8'h00);
    end
endmodule

// ---- hw/mie_data_regs.sv ----
// 64 data registers, two read ports and one write port
`timescale 1ns/1ps
module mie_data_regs
    import mie_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic [REG_SEL_W-1:0] rdAddrA,
    output logic      [DATA_W-1:0]    rdDataA,
    input  wire logic [REG_SEL_W-1:0] rdAddrB,
    output logic      [DATA_W-1:0]    rdDataB,
    input  wire logic                 wrEn,
    input  wire logic [REG_SEL_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0]    wrData
);
    logic [DATA_W-1:0] dregQ [REG_COUNT];

    // ------------------------------------------------------------
    // storage, one entry per generate step
    // ------------------------------------------------------------
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_entry
        always_ff @(posedge clock) begin
            if (reset) begin
                dregQ[i] <= RST_DREG;
            end else if (wrEn && wrAddr == REG_SEL_W'(i)) begin
                dregQ[i] <= wrData;
            end
        end
    end

    assign rdDataA = dregQ[rdAddrA];
    assign rdDataB = dregQ[rdAddrB];
endmodule

// ---- test/mie_core_tb_top.sv ----
// self-checking bench for the step, skip, jump and interrupt-enable core
`timescale 1ns/1ps
module mie_core_tb_top;
    import mie_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic               clock;
    logic               reset;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    logic               hreadyout;
    logic [31:0]        hrdata;
    logic               hresp;
    logic [PC_W-1:0]    progAddr;
    logic [INSTR_W-1:0] progData;
    logic               globalIrqEnable;
    logic [INSTR_W-1:0] progMem [0:1023];
    int                 errorCnt;
    int                 checkCount;

    // program memory read in the same cycle
    assign progData = progMem[progAddr];

    mie_core dut (
        .clock           (clock),
        .reset           (reset),
        .hsel            (hsel),
        .haddr           (haddr),
        .htrans          (htrans),
        .hwrite          (hwrite),
        .hsize           (hsize),
        .hwdata          (hwdata),
        .hready          (hreadyout),
        .hreadyout       (hreadyout),
        .hrdata          (hrdata),
        .hresp           (hresp),
        .progAddr        (progAddr),
        .progData        (progData),
        .globalIrqEnable (globalIrqEnable)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic endSim;
        $display("checks %0d errors %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic fail_wait(input string what);
        errorCnt++;
        $display("ERROR %0t timeout %s", $time, what);
        endSim;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // one single-word transfer; entered right after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) fail_wait("addr");
        htrans <= 2'b00;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) fail_wait("data");
        rd = hrdata;
        chk1(hresp, 1'b0, "hresp");
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk32(x, exp, what);
    endtask

    function automatic logic [31:0] dreg(input int n);
        return 32'h0000_0100 + 32'(n * 4);
    endfunction

    function automatic logic [15:0] ins(input logic [7:0] op, input logic d,
                                        input logic [5:0] r);
        return {op, 1'b0, d, r};
    endfunction

    task automatic start(input logic [9:0] pc);
        wr({20'h0, ADDR_PC}, {22'h0, pc});
        wr({20'h0, ADDR_CTRL}, 32'h0000_0001);
    endtask

    task automatic halt;
        wr({20'h0, ADDR_CTRL}, 32'h0000_0000);
        foreach (progMem[i]) progMem[i] = 16'h0000;
    endtask

    task automatic wait_pc(input logic [9:0] pc);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (progAddr !== pc && n < 50);
        if (n >= 50) fail_wait("pc");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk1(globalIrqEnable, 1'b0, "gie reset");
        rdc({20'h0, ADDR_STATUS}, 32'h0000_0000, "status reset");
        wr(32'h0000_1000, 32'h0000_00FF);
        rdc(32'h0000_1000, 32'h0000_0000, "unmapped");
        $display("test reset done");
    endtask

    task automatic t_step;
        wr(dreg(5), 32'h0000_0001);
        wr(dreg(6), 32'h0000_00FF);
        wr(dreg(63), 32'h0000_0010);
        progMem[16'h20] = ins(OP_REG_INCREMENT, 1'b0, 6'd6);
        progMem[16'h21] = ins(OP_REG_DECREMENT, 1'b0, 6'd63);
        progMem[16'h22] = ins(OP_REG_DECREMENT, 1'b1, 6'd5);
        start(10'h01F);
        repeat (12) @(posedge clock);
        halt;
        rdc({20'h0, ADDR_ACCUM}, 32'h0000_000F, "acc dec");
        rdc(dreg(5), 32'h0000_0000, "r5 dec");
        rdc(dreg(6), 32'h0000_00FF, "r6 kept");
        rdc(dreg(63), 32'h0000_0010, "r63 kept");
        rdc({20'h0, ADDR_STATUS}, 32'h0000_0001, "zero set");
        progMem[16'h30] = ins(OP_REG_INCREMENT, 1'b1, 6'd63);
        progMem[16'h31] = ins(OP_REG_INCREMENT, 1'b1, 6'd6);
        progMem[16'h32] = ins(OP_REG_INCREMENT, 1'b0, 6'd63);
        start(10'h02F);
        repeat (12) @(posedge clock);
        halt;
        rdc(dreg(63), 32'h0000_0011, "r63 inc");
        rdc(dreg(6), 32'h0000_0000, "r6 wrap");
        rdc({20'h0, ADDR_ACCUM}, 32'h0000_0012, "acc inc");
        rdc({20'h0, ADDR_STATUS}, 32'h0000_0000, "zero clear");
        $display("test step done");
    endtask

    task automatic t_skip;
        wr(dreg(10), 32'h0000_00FF);
        wr(dreg(11), 32'h0000_0005);
        progMem[16'h40] = ins(OP_INCREMENT_SKIP_ZERO, 1'b0, 6'd11);
        progMem[16'h41] = ins(OP_REG_INCREMENT, 1'b1, 6'd13);
        progMem[16'h42] = ins(OP_INCREMENT_SKIP_ZERO, 1'b1, 6'd10);
        progMem[16'h43] = ins(OP_REG_INCREMENT, 1'b1, 6'd12);
        start(10'h03F);
        repeat (12) @(posedge clock);
        halt;
        rdc({20'h0, ADDR_ACCUM}, 32'h0000_0006, "acc skip");
        rdc(dreg(11), 32'h0000_0005, "r11 kept");
        rdc(dreg(13), 32'h0000_0001, "no skip");
        rdc(dreg(10), 32'h0000_0000, "r10 wrap");
        rdc(dreg(12), 32'h0000_0000, "flushed");
        rdc({20'h0, ADDR_STATUS}, 32'h0000_0000, "skip zero");
        $display("test skip done");
    endtask

    task automatic t_jump;
        int n;
        wr(dreg(22), 32'h0000_00FF);
        wr({20'h0, ADDR_TPAGE}, 32'h0000_00FE);
        wr({20'h0, ADDR_ACCUM}, 32'h0000_0034);
        rdc({20'h0, ADDR_TPAGE}, 32'h0000_00FE, "page held");
        progMem[16'h80] = ins(OP_REG_INCREMENT, 1'b1, 6'd22);
        progMem[16'h81] = ins(OP_COMPUTED_JUMP, 1'b0, 6'd0);
        progMem[16'h82] = ins(OP_REG_INCREMENT, 1'b1, 6'd20);
        progMem[16'h234] = ins(OP_IRQ_GLOBAL_ON, 1'b0, 6'd0);
        start(10'h07F);
        wait_pc(10'h081);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (progAddr !== 10'h234 && n < 10);
        chk32(32'(n), 32'd2, "jump timing");
        repeat (4) @(posedge clock);
        chk1(globalIrqEnable, 1'b1, "target run");
        halt;
        rdc(dreg(20), 32'h0000_0000, "jump flush");
        rdc(dreg(22), 32'h0000_0000, "pre jump");
        rdc({20'h0, ADDR_STATUS}, 32'h0000_0003, "flags kept");
        $display("test jump done");
    endtask

    task automatic t_irq;
        progMem[16'h100] = ins(OP_IRQ_GLOBAL_OFF, 1'b0, 6'd0);
        progMem[16'h101] = ins(OP_IRQ_GLOBAL_ON, 1'b0, 6'd0);
        progMem[16'h102] = ins(OP_IRQ_GLOBAL_OFF, 1'b0, 6'd0);
        start(10'h0FF);
        wait_pc(10'h101);
        @(posedge clock);
        chk1(globalIrqEnable, 1'b0, "off");
        @(posedge clock);
        chk1(globalIrqEnable, 1'b1, "on");
        @(posedge clock);
        chk1(globalIrqEnable, 1'b0, "off again");
        halt;
        rdc({20'h0, ADDR_STATUS}, 32'h0000_0001, "status irq");
        $display("test irq done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errorCnt   = 0;
        checkCount = 0;
        reset      = 1'b1;
        hsel       = 1'b0;
        haddr      = 32'h0000_0000;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        hsize      = 3'b010;
        hwdata     = 32'h0000_0000;
        foreach (progMem[i]) progMem[i] = 16'h0000;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_reset;
        t_step;
        t_skip;
        t_jump;
        t_irq;
        endSim;
    end

endmodule
